//--- ppdps_pkg.sv
// Package with command codes, field layouts and encodings for the discovery status bank.
package ppdps_pkg;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_DISC_FIRST = 8'h0C;
    localparam logic [7:0] CMD_DISC_LAST = 8'h0F;
    localparam logic [7:0] CMD_POWER_STATE = 8'h10;
    localparam logic [7:0] CMD_ASSIGNED_FIRST = 8'h4C;
    localparam logic [7:0] CMD_ASSIGNED_LAST = 8'h4F;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int CLASS_MSB = 7;
    localparam int CLASS_LSB = 4;
    localparam int DETECT_MSB = 3;
    localparam int DETECT_LSB = 0;
    localparam int NUM_CHAN = 4;

    // ------------------------------------------------------------
    // Requested class encodings
    // ------------------------------------------------------------
    localparam logic [3:0] CLS_UNKNOWN = 4'h0;
    localparam logic [3:0] CLS_THREE = 4'h3;
    localparam logic [3:0] CLS_RSVD_LOW = 4'h5;
    localparam logic [3:0] CLS_ZERO = 4'h6;
    localparam logic [3:0] CLS_EIGHT_SS = 4'hB;
    localparam logic [3:0] CLS_FIVE_DS = 4'hD;

    // ------------------------------------------------------------
    // Detection encodings
    // ------------------------------------------------------------
    localparam logic [3:0] DET_UNKNOWN = 4'h0;
    localparam logic [3:0] DET_RSVD_A = 4'h2;
    localparam logic [3:0] DET_OPEN = 4'h6;
    localparam logic [3:0] DET_RSVD_B = 4'h7;
    localparam logic [3:0] DET_FET_FAULT = 4'hE;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CLASS_WRITE_MS = 5;
    localparam int CLASS_WRITE_CYC = CLASS_WRITE_MS * (CLK_HZ / 1000);
    localparam int CLASS_WRITE_LATENCY = 1;

endpackage

//--- ppdps_status.sv
// Discovery result and power status registers for one group of four channels.
`timescale 1ns/100ps
// Functional notes
// - Four read-only discovery bytes at 0x0C-0x0F: class high, detect low, reset zero.
// - A channel turning off clears its class and detection fields.
// - Class codes 0 unknown, 1-4 classes, 6 class zero; 5 reads as class zero.
// - Single-signature classes five to eight use codes 8 to 11.
// - Codes 7 overcurrent, 12 type-one limited, 13 five dual, 14 reserved, 15 mismatch.
// - Detection codes as listed; reserved codes 2 and 7 are reported unknown.
// - Measured class kept here; granted class kept apart at 0x4C-0x4F.
// - Single-signature pair: class written to both channels within 5 ms.
// - Single-signature pair: class-done event only on the measured channel.
// - Dual-signature pair: each channel reports its own class within 5 ms.
// - A class zero load that is powered is assigned class three.
// - Manual mode, one channel classifying: class eight reported as five dual.
// - Power status at 0x10, bits 3-0 show each channel on.
// - Bits 7-4 set when channel on and drain fell below good threshold.
// - Power-good latches high; clears only on turn-off or reset.
// - Power status bits clear whenever the channel turns off, faults included.
// - On bits of 4-pair ports update per channel as each changes.
// - Single-signature pair: power-good set only once both channels changed.
// - Dual-signature pair: enable and good change events per channel.
module ppdps_status #(
    parameter int CLASS_WRITE_CYC = ppdps_pkg::CLASS_WRITE_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Command port from the serial interface
    input wire logic [7:0] cmdAddr,
    input wire logic cmdRead,
    input wire logic cmdWrite,
    output logic [7:0] rdData_q,
    output logic rdValid_q,
    output logic wrRefused_q,
    // Discovery results from the sequencer
    input wire logic [3:0] classDone,
    input wire logic [3:0][3:0] classCode,
    input wire logic [3:0] detectDone,
    input wire logic [3:0][3:0] detectCode,
    input wire logic [3:0][3:0] allocClass,
    // Channel state and configuration
    input wire logic [3:0] chanOn,
    input wire logic [3:0] drainLowPin,
    input wire logic [1:0] pairSingleSig,
    input wire logic manualOneClass,
    // Events toward the event registers
    output logic [3:0] classDoneEvent_q,
    output logic [3:0] powerEnableChangeEvent_q,
    output logic [3:0] powerGoodChangeEvent_q
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (CLASS_WRITE_CYC < ppdps_pkg::CLASS_WRITE_LATENCY) begin : g_bad_limit
        $error("Class write limit is shorter than the update latency.");
    end

    // ------------------------------------------------------------
    // Class and detection mapping
    // ------------------------------------------------------------
    function automatic logic [3:0] mapClass(input logic [3:0] code, input logic oneCh);
        logic [3:0] res;
        res = code;
        if (code == ppdps_pkg::CLS_RSVD_LOW) begin
            res = ppdps_pkg::CLS_ZERO;
        end
        if (oneCh && code == ppdps_pkg::CLS_EIGHT_SS) begin
            res = ppdps_pkg::CLS_FIVE_DS;
        end
        return res;
    endfunction

    function automatic logic [3:0] mapDetect(input logic [3:0] code);
        logic [3:0] res;
        res = code;
        if (code == ppdps_pkg::DET_RSVD_A || code == ppdps_pkg::DET_RSVD_B) begin
            res = ppdps_pkg::DET_UNKNOWN;
        end else if (code > ppdps_pkg::DET_OPEN && code != ppdps_pkg::DET_FET_FAULT) begin
            res = ppdps_pkg::DET_UNKNOWN;
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Drain sense synchroniser
    // ------------------------------------------------------------
    logic [3:0] drainS1_q;
    logic [3:0] drainS2_q;
    logic [3:0] drainS3_q;
    logic [3:0] drainLow_q;
    wire [3:0] drainAgree = ~(drainS2_q ^ drainS3_q);
    wire [3:0] drainLow_d = (drainAgree & drainS3_q) | (~drainAgree & drainLow_q);

    always_ff @(posedge clk) begin
        if (reset) begin
            drainS1_q <= 4'h0;
            drainS2_q <= 4'h0;
            drainS3_q <= 4'h0;
            drainLow_q <= 4'h0;
        end else begin
            drainS1_q <= drainLowPin;
            drainS2_q <= drainS1_q;
            drainS3_q <= drainS2_q;
            drainLow_q <= drainLow_d;
        end
    end

    // ------------------------------------------------------------
    // Discovery registers
    // ------------------------------------------------------------
    logic [7:0] disc_q [4];
    logic [3:0] assigned_q [4];
    logic [3:0] chanOnPrev_q;
    wire [3:0] turnOff = chanOnPrev_q & ~chanOn;
    wire [3:0] turnOn = ~chanOnPrev_q & chanOn;
    // Partner in a pair is the neighbour channel; pair index is channel / 2.
    wire [3:0] pairSs = {pairSingleSig[1], pairSingleSig[1], pairSingleSig[0], pairSingleSig[0]};
    wire [3:0] partnerDone = {classDone[2], classDone[3], classDone[0], classDone[1]};
    wire [3:0] copyClass = pairSs & partnerDone & ~classDone;
    wire [3:0][3:0] classMapped;
    wire [3:0][3:0] partnerMapped;
    wire [3:0][3:0] detMapped;

    for (genvar i = 0; i < ppdps_pkg::NUM_CHAN; i++) begin : g_map
        assign classMapped[i] = mapClass(classCode[i], manualOneClass);
        assign partnerMapped[i] = mapClass(classCode[i ^ 1], manualOneClass);
        assign detMapped[i] = mapDetect(detectCode[i]);
    end

    // New results win over a turn-off in the same cycle so a result is never lost.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < ppdps_pkg::NUM_CHAN; i++) begin
                disc_q[i] <= ppdps_pkg::REG_RESET;
                assigned_q[i] <= ppdps_pkg::CLS_UNKNOWN;
            end
            chanOnPrev_q <= 4'h0;
        end else begin
            chanOnPrev_q <= chanOn;
            for (int i = 0; i < ppdps_pkg::NUM_CHAN; i++) begin
                if (turnOff[i]) begin
                    disc_q[i] <= ppdps_pkg::REG_RESET;
                end
                if (classDone[i]) begin
                    disc_q[i][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB] <=
                        classMapped[i];
                end else if (copyClass[i]) begin
                    disc_q[i][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB] <=
                        partnerMapped[i];
                end
                if (detectDone[i]) begin
                    disc_q[i][ppdps_pkg::DETECT_MSB:ppdps_pkg::DETECT_LSB] <= detMapped[i];
                end
                if (turnOn[i]) begin
                    if (disc_q[i][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB]
                            == ppdps_pkg::CLS_ZERO) begin
                        assigned_q[i] <= ppdps_pkg::CLS_THREE;
                    end else begin
                        assigned_q[i] <= allocClass[i];
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Power status
    // ------------------------------------------------------------
    logic [3:0] powerOn_q;
    logic [3:0] powerGood_q;
    logic [3:0] pgPend_q;
    wire [3:0] pgPend_d = chanOn & (pgPend_q | drainLow_q);
    wire [3:0] partnerPend = {pgPend_d[2], pgPend_d[3], pgPend_d[0], pgPend_d[1]};
    // Holding the first channel back costs one channel's latency but gives one event.
    wire [3:0] pgSet = pgPend_d & (~pairSs | partnerPend);
    wire [3:0] powerGood_d = chanOn & (powerGood_q | pgSet);

    always_ff @(posedge clk) begin
        if (reset) begin
            powerOn_q <= 4'h0;
            powerGood_q <= 4'h0;
            pgPend_q <= 4'h0;
        end else begin
            powerOn_q <= chanOn;
            powerGood_q <= powerGood_d;
            pgPend_q <= pgPend_d;
        end
    end

    // ------------------------------------------------------------
    // Events
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            classDoneEvent_q <= 4'h0;
            powerEnableChangeEvent_q <= 4'h0;
            powerGoodChangeEvent_q <= 4'h0;
        end else begin
            classDoneEvent_q <= classDone;
            powerEnableChangeEvent_q <= chanOn ^ powerOn_q;
            powerGoodChangeEvent_q <= powerGood_d ^ powerGood_q;
        end
    end

    // ------------------------------------------------------------
    // Command port
    // ------------------------------------------------------------
    wire hitDisc = cmdAddr >= ppdps_pkg::CMD_DISC_FIRST && cmdAddr <= ppdps_pkg::CMD_DISC_LAST;
    wire hitAssigned = cmdAddr >= ppdps_pkg::CMD_ASSIGNED_FIRST
        && cmdAddr <= ppdps_pkg::CMD_ASSIGNED_LAST;
    wire hitPower = cmdAddr == ppdps_pkg::CMD_POWER_STATE;
    wire [1:0] chanSel = cmdAddr[1:0];
    wire [7:0] rdData_d = hitDisc ? disc_q[chanSel]
        : hitPower ? {powerGood_q, powerOn_q}
        : hitAssigned ? {4'h0, assigned_q[chanSel]}
        : ppdps_pkg::REG_RESET;

    // Writes have no path into storage; only writes to 0x0C-0x10 raise a refusal pulse.
    always_ff @(posedge clk) begin
        if (reset) begin
            rdData_q <= ppdps_pkg::REG_RESET;
            rdValid_q <= 1'b0;
            wrRefused_q <= 1'b0;
        end else begin
            rdData_q <= cmdRead ? rdData_d : rdData_q;
            rdValid_q <= cmdRead;
            wrRefused_q <= cmdWrite && (hitDisc || hitPower);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_disc_read;
        @(posedge clk) disable iff (reset)
        cmdRead && cmdAddr == ppdps_pkg::CMD_DISC_FIRST
            |=> rdValid_q && rdData_q == $past(disc_q[0]);
    endproperty
    a_disc_read: assert property (p_disc_read) else $error("Discovery read wrong.");

    property p_off_clear;
        @(posedge clk) disable iff (reset)
        turnOff[0] && !classDone[0] && !copyClass[0] && !detectDone[0]
            |=> disc_q[0] == ppdps_pkg::REG_RESET;
    endproperty
    a_off_clear: assert property (p_off_clear) else $error("Discovery not cleared.");

    property p_rsvd_class;
        @(posedge clk) disable iff (reset)
        classDone[0] && classCode[0] == ppdps_pkg::CLS_RSVD_LOW
            |=> disc_q[0][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB] == ppdps_pkg::CLS_ZERO;
    endproperty
    a_rsvd_class: assert property (p_rsvd_class) else $error("Reserved class kept.");

    property p_rsvd_det;
        @(posedge clk) disable iff (reset)
        detectDone[0] && detectCode[0] == ppdps_pkg::DET_RSVD_B
            |=> disc_q[0][ppdps_pkg::DETECT_MSB:ppdps_pkg::DETECT_LSB] == ppdps_pkg::DET_UNKNOWN;
    endproperty
    a_rsvd_det: assert property (p_rsvd_det) else $error("Reserved detect kept.");

    property p_pair_copy;
        @(posedge clk) disable iff (reset)
        pairSingleSig[0] && classDone[0] && !classDone[1]
            |=> disc_q[1][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB]
                == disc_q[0][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB];
    endproperty
    a_pair_copy: assert property (p_pair_copy) else $error("Pair class not copied.");

    property p_event_own;
        @(posedge clk) disable iff (reset)
        classDone[0] && !classDone[1] |=> classDoneEvent_q[0] && !classDoneEvent_q[1];
    endproperty
    a_event_own: assert property (p_event_own) else $error("Class event on partner.");

    property p_manual_ds;
        @(posedge clk) disable iff (reset)
        manualOneClass && classDone[0] && classCode[0] == ppdps_pkg::CLS_EIGHT_SS
            |=> disc_q[0][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB] == ppdps_pkg::CLS_FIVE_DS;
    endproperty
    a_manual_ds: assert property (p_manual_ds) else $error("Class eight not remapped.");

    property p_on_bits;
        @(posedge clk) disable iff (reset)
        cmdRead && hitPower |=> rdData_q[3:0] == $past(chanOn, 2);
    endproperty
    a_on_bits: assert property (p_on_bits) else $error("On bits wrong.");

    property p_pg_latch;
        @(posedge clk) disable iff (reset)
        powerGood_q[0] && chanOn[0] |=> powerGood_q[0];
    endproperty
    a_pg_latch: assert property (p_pg_latch) else $error("Power good dropped.");

    property p_pg_off;
        @(posedge clk) disable iff (reset)
        !chanOn[0] |=> !powerGood_q[0] && !powerOn_q[0];
    endproperty
    a_pg_off: assert property (p_pg_off) else $error("Status kept while off.");

    property p_pg_joint;
        @(posedge clk) disable iff (reset)
        pairSingleSig[0] && $past(pairSingleSig[0]) && $rose(powerGood_q[0])
            |-> $rose(powerGood_q[1]) || powerGood_q[1];
    endproperty
    a_pg_joint: assert property (p_pg_joint) else $error("Pair good not joint.");

    property p_pec;
        @(posedge clk) disable iff (reset)
        $rose(powerOn_q[0]) |-> powerEnableChangeEvent_q[0] ##1 !powerEnableChangeEvent_q[0];
    endproperty
    a_pec: assert property (p_pec) else $error("Enable change event missing.");

    property p_write_ro;
        @(posedge clk) disable iff (reset)
        cmdWrite && hitDisc |=> wrRefused_q;
    endproperty
    a_write_ro: assert property (p_write_ro) else $error("Write not refused.");

    property p_dual_own;
        @(posedge clk) disable iff (reset)
        !pairSingleSig[1] && classDone[3] && !classDone[2] && !turnOff[2]
            |=> $stable(disc_q[2][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB]);
    endproperty
    a_dual_own: assert property (p_dual_own) else $error("Partner class leaked.");

    property p_class_three;
        @(posedge clk) disable iff (reset)
        turnOn[2] && disc_q[2][ppdps_pkg::CLASS_MSB:ppdps_pkg::CLASS_LSB] == ppdps_pkg::CLS_ZERO
            |=> assigned_q[2] == ppdps_pkg::CLS_THREE;
    endproperty
    a_class_three: assert property (p_class_three) else $error("Class zero not three.");

    property p_good_set;
        @(posedge clk) disable iff (reset)
        chanOn[2] && drainLow_q[2] && !pairSs[2]
            |=> powerGood_q[2];
    endproperty
    a_good_set: assert property (p_good_set) else $error("Power good not set.");

    c_class_pair: cover property (@(posedge clk) disable iff (reset)
        pairSingleSig[0] && classDone[0] ##1 copyClass == 4'h0);
    c_pg_set: cover property (@(posedge clk) disable iff (reset) $rose(powerGood_q[0]));
    c_turn_off: cover property (@(posedge clk) disable iff (reset) turnOff[0] && powerGood_q[0]);
    c_pair_good: cover property (@(posedge clk) disable iff (reset)
        $rose(powerGood_q[1]) && pairSingleSig[0]);

endmodule // ppdps_status

//--- ppdps_host_model.sv
// Host-side model that issues register commands to the status bank.
`timescale 1ns/100ps
module ppdps_host_model (
    // Clock
    input wire logic clk,
    // Command strobes toward the bank
    output logic [7:0] cmdAddr,
    output logic cmdRead,
    output logic cmdWrite,
    // Answers from the bank
    input wire logic [7:0] rdData_q,
    input wire logic rdValid_q,
    input wire logic wrRefused_q
);
    initial begin
        cmdAddr = 8'h00;
        cmdRead = 1'b0;
        cmdWrite = 1'b0;
    end

    // ------------------------------------------------------------
    // Command tasks
    // ------------------------------------------------------------
    // The address is inverted after the strobe; answer and valid flag are sampled 1 ns after the edge that registers the read.
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(posedge clk);
        cmdAddr <= a;
        cmdRead <= 1'b1;
        @(posedge clk);
        cmdRead <= 1'b0;
        cmdAddr <= ~a;
        #1;
        v = rdValid_q;
        d = rdData_q;
    endtask

    task automatic write_reg(input logic [7:0] a, output logic r);
        @(posedge clk);
        cmdAddr <= a;
        cmdWrite <= 1'b1;
        @(posedge clk);
        cmdWrite <= 1'b0;
        cmdAddr <= ~a;
        #1;
        r = wrRefused_q;
    endtask
endmodule // ppdps_host_model

//--- tb_pse_port_discovery_power_status.sv
// Self-checking testbench for the discovery and power status bank.
`timescale 1ns/100ps
module tb_pse_port_discovery_power_status;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [7:0] cmdAddr;
    logic cmdRead;
    logic cmdWrite;
    logic [7:0] rdData_q;
    logic rdValid_q;
    logic wrRefused_q;
    logic [3:0] classDone = 4'h0;
    logic [3:0][3:0] classCode = '0;
    logic [3:0] detectDone = 4'h0;
    logic [3:0][3:0] detectCode = '0;
    logic [3:0][3:0] allocClass = '0;
    logic [3:0] chanOn = 4'h0;
    logic [3:0] drainLowPin = 4'h0;
    logic [1:0] pairSingleSig = 2'b00;
    logic manualOneClass = 1'b0;
    logic [3:0] classDoneEvent_q;
    logic [3:0] powerEnableChangeEvent_q;
    logic [3:0] powerGoodChangeEvent_q;
    int bad_count = 0;
    int total_checks = 0;
    int cycles = 0;
    int disc [4] = '{0, 0, 0, 0};
    logic [3:0] onM = 4'h0;
    logic [3:0] goodM = 4'h0;
    logic [3:0] seenLow = 4'h0;
    logic [7:0] rd;
    logic flag;

    always #10 clk = ~clk;

    ppdps_status dut (.clk(clk), .reset(reset), .cmdAddr(cmdAddr), .cmdRead(cmdRead),
        .cmdWrite(cmdWrite), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
        .wrRefused_q(wrRefused_q), .classDone(classDone), .classCode(classCode),
        .detectDone(detectDone), .detectCode(detectCode), .allocClass(allocClass),
        .chanOn(chanOn), .drainLowPin(drainLowPin), .pairSingleSig(pairSingleSig),
        .manualOneClass(manualOneClass), .classDoneEvent_q(classDoneEvent_q),
        .powerEnableChangeEvent_q(powerEnableChangeEvent_q),
        .powerGoodChangeEvent_q(powerGoodChangeEvent_q));

    ppdps_host_model host (.clk(clk), .cmdAddr(cmdAddr), .cmdRead(cmdRead),
        .cmdWrite(cmdWrite), .rdData_q(rdData_q), .rdValid_q(rdValid_q),
        .wrRefused_q(wrRefused_q));

    // ------------------------------------------------------------
    // Checking and reference model
    // ------------------------------------------------------------
    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // The ceiling sits well above the roughly 230 cycles the sequence needs.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            finish_test;
        end
    end

    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        if (a >= 8'h0C && a <= 8'h0F) begin
            return 8'(disc[a - 8'h0C]);
        end
        return (a == 8'h10) ? {goodM, onM} : 8'h00;
    endfunction

    task automatic cmp_reg(input logic [7:0] a);
        logic [7:0] d;
        logic v;
        host.read_reg(a, d, v);
        check({7'h00, v}, 8'h01, "read answer");
        check(d, exp_byte(a), "register byte");
    endtask

    task automatic classify(input int ch, input int c, input int d);
        int cls;
        int det;
        @(posedge clk);
        cls = (c == 5) ? 6 : ((manualOneClass && c == 11) ? 13 : c);
        det = (d inside {0, 1, 3, 4, 5, 6, 14}) ? d : 0;
        classDone[ch] <= 1'b1;
        classCode[ch] <= 4'(c);
        detectDone[ch] <= 1'b1;
        detectCode[ch] <= 4'(d);
        @(posedge clk);
        classDone <= 4'h0;
        detectDone <= 4'h0;
        #1;
        check({4'h0, classDoneEvent_q}, 8'(1 << ch), "class event");
        disc[ch] = cls * 16 + det;
        if (pairSingleSig[ch / 2]) begin
            disc[ch ^ 1] = cls * 16 + (disc[ch ^ 1] % 16);
        end
    endtask

    task automatic set_on(input logic [3:0] m);
        logic [3:0] seen;
        seen = 4'h0;
        @(posedge clk);
        chanOn <= m;
        repeat (4) begin
            @(posedge clk);
            #1;
            seen = seen | powerEnableChangeEvent_q;
        end
        check({4'h0, seen}, {4'h0, onM ^ m}, "enable change event");
        for (int i = 0; i < 4; i++) begin
            if (onM[i] && !m[i]) begin
                disc[i] = 0;
            end
        end
        onM = m;
        goodM = goodM & m;
        seenLow = seenLow & m;
    endtask

    task automatic drive_drain(input logic [3:0] m);
        logic [3:0] seen;
        logic [3:0] nextGood;
        seen = 4'h0;
        @(posedge clk);
        drainLowPin <= m;
        repeat (10) begin
            @(posedge clk);
            #1;
            seen = seen | powerGoodChangeEvent_q;
        end
        seenLow = seenLow | (m & onM);
        nextGood = seenLow;
        for (int p = 0; p < 2; p++) begin
            if (pairSingleSig[p] && seenLow[2 * p +: 2] != 2'b11) begin
                nextGood[2 * p +: 2] = 2'b00;
            end
        end
        nextGood = nextGood | goodM;
        check({4'h0, seen}, {4'h0, nextGood ^ goodM}, "good change event");
        goodM = nextGood;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(96359));
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        allocClass <= {4'($urandom()), 4'h9, 8'($urandom())};
        for (int a = 8'h0C; a <= 8'h10; a++) cmp_reg(8'(a));
        cmp_reg(8'h20);
        for (int i = 0; i < 16; i++) begin
            int ch;
            ch = 2 + $urandom_range(1);
            classify(ch, i, 15 - i);
            cmp_reg(8'(8'h0C + ch));
        end
        @(posedge clk) pairSingleSig <= 2'b01;
        classify(0, 11, 4);
        cmp_reg(8'h0C);
        cmp_reg(8'h0D);
        classify(3, 8, 3);
        cmp_reg(8'h0E);
        cmp_reg(8'h0F);
        @(posedge clk) manualOneClass <= 1'b1;
        classify(2, 11, 4);
        cmp_reg(8'h0E);
        @(posedge clk) manualOneClass <= 1'b0;
        for (int a = 8'h0C; a <= 8'h10; a++) begin
            host.write_reg(8'(a), flag);
            check({7'h00, flag}, 8'h01, "write refused");
            cmp_reg(8'(a));
        end
        host.write_reg(8'h30, flag);
        check({7'h00, flag}, 8'h00, "write outside bank");
        classify(2, 6, 4);
        set_on(4'b0111);
        cmp_reg(8'h10);
        host.read_reg(8'h4E, rd, flag);
        check({4'h0, rd[3:0]}, 8'h03, "assigned class");
        cmp_reg(8'h0E);
        drive_drain(4'b0100);
        cmp_reg(8'h10);
        drive_drain(4'b0001);
        cmp_reg(8'h10);
        drive_drain(4'b0000);
        cmp_reg(8'h10);
        drive_drain(4'b0010);
        cmp_reg(8'h10);
        set_on(4'b0100);
        for (int a = 8'h0C; a <= 8'h10; a++) cmp_reg(8'(a));
        set_on(4'b0000);
        cmp_reg(8'h0E);
        cmp_reg(8'h10);
        @(posedge clk) pairSingleSig <= 2'b11;
        classify(3, 9, 5);
        cmp_reg(8'h0E);
        cmp_reg(8'h0F);
        finish_test;
    end
endmodule // tb_pse_port_discovery_power_status
